// ==== hw/sbr_sio.sv ====
// sbr_sio: serial unit with clock-synchronous 8-bit mode and two-wire release / start
// assumes wishbone classic slave, pins sampled from outside the clock domain
//
// Decided for this implementation: the Wishbone register port.
`default_nettype none
module sbr_sio
   import sbr_pkg::*;
(
   input  wire logic              clk,
   input  wire logic              srst,
   input  wire logic              wbCyc,
   input  wire logic              wbStb,
   input  wire logic              wbWe,
   input  wire logic [ADR_W-1:0]  wbAdr,
   input  wire logic [3:0]        wbSel,
   input  wire logic [31:0]       wbDatW,
   output logic      [31:0]       wbDatR,
   output logic                   wbAck,
   output logic                   irq,
   input  wire logic              sckIn,
   output logic                   sckOut,
   output logic                   sckOeN,
   output logic                   serOut,
   input  wire logic              serIn,
   input  wire logic              sdaIn,
   output logic                   sdaOut,
   output logic                   sdaOeN,
   input  wire logic              sclIn,
   output logic                   sclOut,
   output logic                   sclOeN
);
   // ----------------------------------------
   // register state
   // ----------------------------------------
   logic              enable_ff;
   logic              start_ff;
   logic              abort_ff;
   logic [1:0]        dir_ff;
   logic [2:0]        clkSel_ff;
   logic [1:0]        mode_ff;
   logic              masterSel_ff;
   logic              trx_ff;
   logic              busBusy_ff;
   logic              pin_ff;
   logic              lrb_ff;
   logic [7:0]        dbuf_ff;
   logic              txFull_ff;
   logic              rxFull_ff;
   logic [IRQ_N-1:0]  istat_ff;
   logic [IRQ_N-1:0]  imask_ff;
   logic [IRQ_N-1:0]  ievt;
   logic [2:0]        sckSync_ff;
   logic [1:0]        siSync_ff;
   logic [1:0]        sclSync_ff;
   logic [1:0]        sdaSync_ff;
   sbr_sio_t          sio_ff;
   sbr_tw_t           tw_ff;
   logic [7:0]        shift_ff;
   logic [3:0]        bitCnt_ff;
   logic              tick;
   logic              extClk;
   logic              fallEdge;
   logic              riseEdge;
   logic              byteDone;
   logic              needTx;
   logic              needRx;
   logic              canGo;

   // ----------------------------------------
   // wishbone decode
   // ----------------------------------------
   logic              req;
   logic              wr;
   logic              rd;
   logic [IDX_W-1:0]  idx;
   logic              hitC0;
   logic              hitC1;
   logic              hitDb;
   logic              hitC2;
   logic              hitIs;
   logic              hitIm;
   logic              wrEn;
   logic [7:0]        wd;
   logic [7:0]        rdata;
   logic [7:0]        statRd;

   assign req   = wbCyc && wbStb && !wbAck;
   assign wr    = req && wbWe && wbSel[0];
   assign rd    = req && !wbWe;
   assign idx   = wbAdr[ADR_W-1:2];
   assign hitC0 = idx == IDX_W'(OFS_CTRL_ZERO[7:0]);
   assign hitC1 = idx == IDX_W'(OFS_CTRL_ONE[7:0]);
   assign hitDb = idx == IDX_W'(OFS_DATA_BUF[7:0]);
   assign hitC2 = idx == IDX_W'(OFS_CTRL_TWO[7:0]);
   assign hitIs = idx == IDX_W'(OFS_IRQ_STAT[7:0]);
   assign hitIm = idx == IDX_W'(OFS_IRQ_MASK[7:0]);
   assign wrEn  = wr && enable_ff;
   assign wd    = wbDatW[7:0];

   always_comb begin
      if (mode_ff == MODE_TWI)
         statRd = {masterSel_ff, trx_ff, busBusy_ff, pin_ff, 3'h7, lrb_ff};
      else
         statRd = {4'hf, sio_ff != SIO_IDLE, sio_ff == SIO_SHIFT, 2'h3};
      rdata = 8'h00;
      if (hitC0)
         rdata = {enable_ff, 7'h00};
      else if (hitC1)
         rdata = {4'h0, 1'b1, clkSel_ff};
      else if (hitDb)
         rdata = dbuf_ff;
      else if (hitC2)
         rdata = statRd;
      else if (hitIs)
         rdata = {6'h00, istat_ff};
      else if (hitIm)
         rdata = {6'h00, imask_ff};
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         wbAck  <= 1'b0;
         wbDatR <= 32'h00000000;
      end else begin
         wbAck  <= req;
         wbDatR <= rd ? {24'h000000, rdata} : 32'h00000000;
      end
   end

   // ----------------------------------------
   // pin synchronisers
   // ----------------------------------------
   always_ff @(posedge clk) begin
      if (srst) begin
         sckSync_ff <= 3'h7;
         siSync_ff  <= 2'h3;
         sclSync_ff <= 2'h3;
         sdaSync_ff <= 2'h3;
      end else begin
         sckSync_ff <= {sckSync_ff[1:0], sckIn};
         siSync_ff  <= {siSync_ff[0], serIn};
         sclSync_ff <= {sclSync_ff[0], sclIn};
         sdaSync_ff <= {sdaSync_ff[0], sdaIn};
      end
   end

   // ----------------------------------------
   // control registers
   // ----------------------------------------
   always_ff @(posedge clk) begin
      if (srst)
         enable_ff <= 1'b0;
      else if (wr && hitC0)
         enable_ff <= wd[B_ENABLE];
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         start_ff  <= 1'b0;
         abort_ff  <= 1'b0;
         dir_ff    <= DIR_TX;
         clkSel_ff <= RST_CLK_SEL;
      end else if (wrEn && hitC1) begin
         start_ff  <= wd[B_START];
         abort_ff  <= wd[B_ABORT];
         dir_ff    <= wd[B_DIR_HI:B_DIR_LO];
         clkSel_ff <= wd[B_CLK_HI:0];
      end else if (!enable_ff) begin
         start_ff  <= 1'b0;
      end
   end

   always_ff @(posedge clk) begin
      if (srst)
         mode_ff <= MODE_PORT;
      else if (wrEn && hitC2)
         mode_ff <= wd[B_MODE_HI:B_MODE_LO];
   end

   // ----------------------------------------
   // interrupt status and mask
   // ----------------------------------------
   always_ff @(posedge clk) begin
      if (srst) begin
         istat_ff <= '0;
         imask_ff <= '0;
         irq      <= 1'b0;
      end else begin
         istat_ff <= (istat_ff & ~((wrEn && hitIs) ? wd[IRQ_N-1:0] : '0)) | ievt;
         if (wrEn && hitIm)
            imask_ff <= wd[IRQ_N-1:0];
         irq <= |(istat_ff & imask_ff);
      end
   end

   // ----------------------------------------
   // serial clock source
   // ----------------------------------------
   assign extClk = clkSel_ff == CLK_EXT;

   sbr_clk_div u_div (
      .clk  (clk),
      .srst (srst),
      .run  ((sio_ff == SIO_SHIFT && !extClk) || tw_ff != TW_IDLE),
      .sel  (clkSel_ff),
      .tick (tick)
   );

   always_comb begin
      if (extClk) begin
         fallEdge = sckSync_ff[2] && !sckSync_ff[1];
         riseEdge = !sckSync_ff[2] && sckSync_ff[1];
      end else begin
         fallEdge = tick && sckOut;
         riseEdge = tick && !sckOut;
      end
   end

   // ----------------------------------------
   // sio shift engine
   // ----------------------------------------
   assign needTx   = dir_ff != DIR_RX;
   assign needRx   = dir_ff != DIR_TX;
   assign canGo    = (!needTx || txFull_ff) && (!needRx || !rxFull_ff);
   assign byteDone = sio_ff == SIO_SHIFT && riseEdge && bitCnt_ff == BIT_LAST - 4'h1;

   always_ff @(posedge clk) begin
      if (srst || !enable_ff || mode_ff != MODE_SIO || abort_ff) begin
         sio_ff    <= SIO_IDLE;
         bitCnt_ff <= 4'h0;
         shift_ff  <= 8'h00;
      end else begin
         case (sio_ff)
            SIO_IDLE, SIO_WAIT: begin
               bitCnt_ff <= 4'h0;
               if (start_ff && canGo) begin
                  sio_ff   <= SIO_SHIFT;
                  shift_ff <= dbuf_ff;
               end else if (!start_ff) begin
                  sio_ff <= SIO_IDLE;
               end
            end
            SIO_SHIFT: begin
               if (riseEdge) begin
                  shift_ff  <= {siSync_ff[1], shift_ff[7:1]};
                  bitCnt_ff <= bitCnt_ff + 4'h1;
               end
               if (byteDone)
                  sio_ff <= start_ff ? SIO_WAIT : SIO_IDLE;
            end
            default: sio_ff <= SIO_IDLE;
         endcase
      end
   end

   // data buffer: written by software, loaded by reception
   always_ff @(posedge clk) begin
      if (srst) begin
         dbuf_ff   <= 8'h00;
         txFull_ff <= 1'b0;
         rxFull_ff <= 1'b0;
      end else begin
         if (wrEn && hitDb) begin
            dbuf_ff   <= wd;
            txFull_ff <= 1'b1;
         end else if (sio_ff != SIO_SHIFT && start_ff && canGo && needTx) begin
            txFull_ff <= 1'b0;
         end
         if (byteDone && needRx) begin
            dbuf_ff   <= {siSync_ff[1], shift_ff[7:1]};
            rxFull_ff <= 1'b1;
         end else if (rd && hitDb && enable_ff) begin
            rxFull_ff <= 1'b0;
         end
      end
   end

   always_comb begin
      ievt          = '0;
      ievt[IRQ_BUF] = (sio_ff != SIO_SHIFT && start_ff && canGo && needTx && enable_ff
                       && mode_ff == MODE_SIO && !abort_ff) || (byteDone && needRx);
      ievt[IRQ_END] = byteDone && !start_ff;
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         sckOut <= 1'b1;
         sckOeN <= 1'b1;
         serOut <= 1'b1;
      end else begin
         sckOeN <= !(enable_ff && mode_ff == MODE_SIO && !extClk);
         if (sio_ff != SIO_SHIFT)
            sckOut <= 1'b1;
         else if (tick && !extClk)
            sckOut <= !sckOut;
         if (sio_ff == SIO_SHIFT && fallEdge && needTx)
            serOut <= shift_ff[0];
      end
   end

   // ----------------------------------------
   // two-wire bus control
   // ----------------------------------------
   always_ff @(posedge clk) begin
      if (srst) begin
         tw_ff  <= TW_IDLE;
         masterSel_ff <= 1'b0;
         trx_ff       <= 1'b0;
         busBusy_ff   <= 1'b0;
         pin_ff       <= 1'b1;
         lrb_ff       <= 1'b1;
         sdaOeN <= 1'b1;
         sclOeN <= 1'b1;
         sdaOut <= 1'b0;
         sclOut <= 1'b0;
      end else begin
         if (!busBusy_ff)
            lrb_ff <= sclSync_ff[1];
         case (tw_ff)
            TW_IDLE: begin
               if (wrEn && hitC2 && mode_ff == MODE_TWI) begin
                  if (wd[7:4] == RELEASE_PAT) begin
                     masterSel_ff <= 1'b0;
                     trx_ff       <= 1'b0;
                     busBusy_ff   <= 1'b0;
                     pin_ff <= 1'b1;
                     sdaOeN <= 1'b1;
                     sclOeN <= 1'b1;
                  end else if (wd[7:4] == START_PAT && !busBusy_ff) begin
                     masterSel_ff <= 1'b1;
                     trx_ff <= 1'b1;
                     sdaOeN <= 1'b0;
                     tw_ff  <= TW_START;
                  end else if (wd[7:4] == STOP_PAT && busBusy_ff) begin
                     sdaOeN <= 1'b0;
                     sclOeN <= 1'b1;
                     tw_ff  <= TW_STOP;
                  end
               end
            end
            TW_START: begin
               if (tick) begin
                  sclOeN <= 1'b0;
                  busBusy_ff <= 1'b1;
                  pin_ff <= 1'b0;
                  tw_ff  <= TW_IDLE;
               end
            end
            TW_STOP: begin
               if (tick && sclSync_ff[1]) begin
                  sdaOeN <= 1'b1;
                  busBusy_ff   <= 1'b0;
                  masterSel_ff <= 1'b0;
                  trx_ff <= 1'b0;
                  pin_ff <= 1'b1;
                  tw_ff  <= TW_IDLE;
               end
            end
            default: tw_ff <= TW_IDLE;
         endcase
      end
   end
endmodule
`default_nettype wire

// ==== hw/sbr_pkg.sv ====
// sbr_pkg: shared constants for the serial bus sio / two-wire release / start block
// assumes a 50 MHz system clock and a classic wishbone register bus
`default_nettype none
package sbr_pkg;
   // ----------------------------------------
   // register map
   // ----------------------------------------
   localparam logic [31:0] OFS_CTRL_ONE   = 32'hfffff250;
   localparam logic [31:0] OFS_DATA_BUF   = 32'hfffff251;
   localparam logic [31:0] OFS_CTRL_TWO   = 32'hfffff253;
   localparam logic [31:0] OFS_CTRL_ZERO  = 32'hfffff257;
   localparam logic [31:0] OFS_IRQ_STAT   = 32'hfffff258;
   localparam logic [31:0] OFS_IRQ_MASK   = 32'hfffff259;
   localparam int          IDX_W          = 10;
   localparam int          ADR_W          = 12;
   // ----------------------------------------
   // field positions
   // ----------------------------------------
   localparam int          B_ENABLE       = 7;
   localparam int          B_START        = 7;
   localparam int          B_ABORT        = 6;
   localparam int          B_DIR_HI       = 5;
   localparam int          B_DIR_LO       = 4;
   localparam int          B_CLK_HI       = 2;
   localparam int          B_MASTER       = 7;
   localparam int          B_TRX          = 6;
   localparam int          B_BUSY         = 5;
   localparam int          B_PIN          = 4;
   localparam int          B_MODE_HI      = 3;
   localparam int          B_MODE_LO      = 2;
   localparam int          B_XFER_ON      = 3;
   localparam int          B_SHIFT_ON     = 2;
   localparam int          B_LRB          = 0;
   localparam int          IRQ_N          = 2;
   localparam int          IRQ_BUF        = 0;
   localparam int          IRQ_END        = 1;
   // ----------------------------------------
   // codes and reset values
   // ----------------------------------------
   localparam logic [1:0]  DIR_TX         = 2'h0;
   localparam logic [1:0]  DIR_TXRX       = 2'h2;
   localparam logic [1:0]  DIR_RX         = 2'h3;
   localparam logic [1:0]  MODE_PORT      = 2'h0;
   localparam logic [1:0]  MODE_SIO       = 2'h1;
   localparam logic [1:0]  MODE_TWI       = 2'h2;
   localparam logic [2:0]  CLK_EXT        = 3'h7;
   localparam logic [2:0]  RST_CLK_SEL    = 3'h1;
   localparam logic [3:0]  RELEASE_PAT    = 4'h1;
   localparam logic [3:0]  START_PAT      = 4'hf;
   localparam logic [3:0]  STOP_PAT       = 4'hd;
   localparam logic [3:0]  BIT_LAST       = 4'h8;
   localparam int          DIV_W          = 10;
   localparam int          DIV_SHIFT      = 4;
   typedef enum logic [1:0] {SIO_IDLE, SIO_SHIFT, SIO_WAIT} sbr_sio_t;
   typedef enum logic [1:0] {TW_IDLE, TW_START, TW_STOP} sbr_tw_t;
endpackage
`default_nettype wire

// ==== hw/sbr_clk_div.sv ====
// sbr_clk_div: half-period tick for the internal serial clock
// assumes sel is stable while run is high
`default_nettype none
module sbr_clk_div
   import sbr_pkg::*;
(
   input  wire logic        clk,
   input  wire logic        srst,
   input  wire logic        run,
   input  wire logic [2:0]  sel,
   output logic             tick
);
   logic [DIV_W-1:0] cnt_ff;
   logic [DIV_W-1:0] limit;

   // half period is 2^(n+1) clocks, n = sel + 3
   assign limit = DIV_W'((32'h1 << (32'(sel) + DIV_SHIFT)) - 32'h1);

   always_ff @(posedge clk) begin
      if (srst || !run) begin
         cnt_ff <= '0;
         tick   <= 1'b0;
      end else if (cnt_ff == limit) begin
         cnt_ff <= '0;
         tick   <= 1'b1;
      end else begin
         cnt_ff <= cnt_ff + DIV_W'(1);
         tick   <= 1'b0;
      end
   end
endmodule
`default_nettype wire

// ==== bench/sbr_sio_assertions.sv ====
// sbr_sio_assertions: port-level checks for sbr_sio
// assumes one wishbone master and a 50 MHz clk
`default_nettype none
module sbr_sio_assertions
   import sbr_pkg::*;
(
   input wire logic             clk,
   input wire logic             srst,
   input wire logic             wbCyc,
   input wire logic             wbStb,
   input wire logic             wbWe,
   input wire logic [ADR_W-1:0] wbAdr,
   input wire logic [3:0]       wbSel,
   input wire logic [31:0]      wbDatW,
   input wire logic [31:0]      wbDatR,
   input wire logic             wbAck,
   input wire logic             sckOut,
   input wire logic             sckOeN,
   input wire logic             sdaOeN,
   input wire logic             sclOeN
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking cb @(posedge clk); endclocking
   default disable iff (srst);
   logic        enable_ff;
   logic [2:0]  sel_ff;
   logic [10:0] lowCnt_ff;
   wire         wrOk = wbAck && wbWe && wbSel[0];
   wire         rdOk = wbAck && !wbWe;
   // unit enable as software last wrote it
   always_ff @(posedge clk) begin
      if (srst) enable_ff <= 1'b0;
      else if (wrOk && wbAdr == 12'h15c) enable_ff <= wbDatW[7];
   end
   // clock select as software last wrote it
   always_ff @(posedge clk) begin
      if (srst) sel_ff <= 3'h1;
      else if (wrOk && enable_ff && wbAdr == 12'h140) sel_ff <= wbDatW[2:0];
   end
   // length of the current low phase of the internal clock
   always_ff @(posedge clk) begin
      if (srst || sckOut) lowCnt_ff <= 11'h0;
      else lowCnt_ff <= lowCnt_ff + 11'h1;
   end
   a_ack_pulse: assert property (wbAck |=> !wbAck)
      else $error("ack held two cycles");
   a_ack_latency: assert property (wbCyc && wbStb && !wbAck |=> wbAck)
      else $error("no ack one cycle after request");
   a_data_idle: assert property (!wbAck |-> wbDatR == 32'h0)
      else $error("read data not zero outside ack");
   a_zero_read: assert property (rdOk && wbAdr == 12'h15c |->
      wbDatR[31:8] == 24'h0 && wbDatR[6:0] == 7'h0) else $error("control zero spare bits");
   a_one_read: assert property (rdOk && wbAdr == 12'h140 |->
      wbDatR == {27'h1, sel_ff}) else $error("control one readback wrong");
   a_status_ones: assert property (rdOk && wbAdr == 12'h14c |->
      wbDatR[1] && wbDatR[31:8] == 24'h0) else $error("status fixed bits wrong");
   a_release_lines: assert property (wrOk && enable_ff && wbAdr == 12'h14c &&
      wbDatW[7:2] == 6'h06 |=> (sdaOeN && sclOeN)[*3]) else $error("release drove a line");
   a_sck_half: assert property ($rose(sckOut) && !sckOeN && sel_ff != CLK_EXT |->
      lowCnt_ff == (11'h1 << (4'(sel_ff) + 4'h4))) else $error("serial clock low phase length");
endmodule
bind sbr_sio sbr_sio_assertions chk_u (.clk(clk), .srst(srst), .wbCyc(wbCyc),
   .wbStb(wbStb), .wbWe(wbWe), .wbAdr(wbAdr), .wbSel(wbSel), .wbDatW(wbDatW),
   .wbDatR(wbDatR), .wbAck(wbAck), .sckOut(sckOut), .sckOeN(sckOeN),
   .sdaOeN(sdaOeN), .sclOeN(sclOeN));
`default_nettype wire

// ==== bench/sbr_peer.sv ====
// sbr_peer: serial peer and pulled-up two-wire bus beside sbr_sio
// assumes the bench raises go once per received byte
`default_nettype none
module sbr_peer (
   input  wire logic  sckOut,
   input  wire logic  sckOeN,
   input  wire logic  serOut,
   input  wire logic  sdaOut,
   input  wire logic  sdaOeN,
   input  wire logic  sclOut,
   input  wire logic  sclOeN,
   input  wire logic  go,
   input  wire logic  holdScl,
   output logic       sckIn,
   output logic       serIn,
   output logic       sdaIn,
   output logic       sclIn,
   output logic [7:0] rxByte
);
   timeunit 1ns;
   timeprecision 1ps;
   localparam logic [7:0] PAT = 8'ha5;
   // pull-ups; another agent may hold the clock line low
   assign sdaIn = sdaOeN | sdaOut;
   assign sclIn = (sclOeN | sclOut) & ~holdScl;
   // transmit data taken on the rising internal clock, lsb first
   always @(posedge sckOut) begin
      if (!sckOeN) rxByte <= {serOut, rxByte[7:1]};
   end
   // external clock of 160 ns, still between frames; data changes on the fall
   initial begin
      sckIn = 1'b1;
      serIn = 1'b0;
      rxByte = 8'h00;
      forever begin
         @(posedge go);
         for (int i = 0; i < 8; i++) begin
            serIn = PAT[i];
            sckIn = 1'b0;
            #80;
            sckIn = 1'b1;
            #80;
         end
         serIn = ~serIn;
      end
   end
endmodule
`default_nettype wire

// ==== bench/testbench.sv ====
// testbench: register, sio and two-wire scenarios for sbr_sio
// assumes sbr_peer as far side and the bound checker
`default_nettype none
module testbench;
   timeunit 1ns;
   timeprecision 1ps;
   logic        clk, srst, wbCyc, wbStb, wbWe, go, holdScl;
   logic [11:0] wbAdr;
   logic [3:0]  wbSel;
   logic [31:0] wbDatW, wbDatR, q;
   logic        wbAck, irq, sckIn, sckOut, sckOeN, serOut, serIn;
   logic        sdaIn, sdaOut, sdaOeN, sclIn, sclOut, sclOeN;
   logic [7:0]  rxByte;
   int          miscompares, checks_done;
   sbr_sio dut_u (.clk(clk), .srst(srst), .wbCyc(wbCyc), .wbStb(wbStb), .wbWe(wbWe),
      .wbAdr(wbAdr), .wbSel(wbSel), .wbDatW(wbDatW), .wbDatR(wbDatR), .wbAck(wbAck),
      .irq(irq), .sckIn(sckIn), .sckOut(sckOut), .sckOeN(sckOeN), .serOut(serOut),
      .serIn(serIn), .sdaIn(sdaIn), .sdaOut(sdaOut), .sdaOeN(sdaOeN), .sclIn(sclIn),
      .sclOut(sclOut), .sclOeN(sclOeN));
   sbr_peer peer_u (.sckOut(sckOut), .sckOeN(sckOeN), .serOut(serOut), .sdaOut(sdaOut),
      .sdaOeN(sdaOeN), .sclOut(sclOut), .sclOeN(sclOeN), .go(go), .holdScl(holdScl),
      .sckIn(sckIn), .serIn(serIn), .sdaIn(sdaIn), .sclIn(sclIn), .rxByte(rxByte));
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      checks_done++;
      if (g !== e) begin
         $display("BAD %s expected %h seen %h", nm, e, g);
         miscompares++;
      end
   endtask
   // one classic cycle, held until ack is sampled
   task automatic wb(input logic we, input logic [11:0] a, input logic [7:0] d);
      int n;
      n = 0;
      wbCyc <= 1'b1;
      wbStb <= 1'b1;
      wbWe <= we;
      wbAdr <= a;
      wbDatW <= {24'h0, d};
      wbSel <= 4'hf;
      do begin
         @(posedge clk);
         n++;
      end while (wbAck !== 1'b1 && n < 20);
      if (n >= 20) chk("ack", 32'h1, 32'h0);
      q = wbDatR;
      wbCyc <= 1'b0;
      wbStb <= 1'b0;
      @(posedge clk);
   endtask
   task automatic rdc(input logic [11:0] a, input logic [31:0] e, input string nm);
      wb(1'b0, a, 8'h00);
      chk(nm, e, q);
   endtask
   task automatic give_verdict;
      $display("checks %0d miscompares %0d", checks_done, miscompares);
      if (miscompares == 0 && checks_done > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask
   task automatic t_regs;
      rdc(12'h15c, 32'h00, "ctrl0 reset");
      rdc(12'h140, 32'h09, "ctrl1 reset");
      rdc(12'h14c, 32'hf3, "status reset");
      wb(1'b1, 12'h140, 8'h47);
      rdc(12'h140, 32'h09, "ctrl1 while off");
      wb(1'b1, 12'h15c, 8'hff);
      rdc(12'h15c, 32'h80, "ctrl0 on");
      wb(1'b1, 12'h100, 8'hff);
      rdc(12'h100, 32'h00, "unmapped");
      wb(1'b1, 12'h140, 8'h41);
      for (int s = 0; s < 8; s++) begin
         wb(1'b1, 12'h140, 8'h60 | 8'(s));
         rdc(12'h140, 32'h08 | 32'(s), "clock select");
      end
   endtask
   task automatic t_tx;
      int n;
      wb(1'b1, 12'h14c, 8'h04);
      wb(1'b1, 12'h140, 8'h40);
      wb(1'b1, 12'h164, 8'h03);
      wb(1'b1, 12'h144, 8'h3c);
      wb(1'b1, 12'h140, 8'h80);
      wb(1'b0, 12'h14c, 8'h00);
      chk("transfer flag", 32'h1, {31'h0, q[3]});
      wb(1'b1, 12'h140, 8'h00);
      n = 0;
      do begin
         wb(1'b0, 12'h14c, 8'h00);
         n++;
      end while (q[3] !== 1'b0 && n < 200);
      chk("status ended", 32'hf3, q);
      chk("peer byte", 32'h3c, {24'h0, rxByte});
      chk("irq raised", 32'h1, {31'h0, irq});
      wb(1'b1, 12'h164, 8'h00);
      chk("irq masked", 32'h0, {31'h0, irq});
      wb(1'b1, 12'h160, 8'h03);
      wb(1'b1, 12'h164, 8'h03);
      chk("irq cleared", 32'h0, {31'h0, irq});
   endtask
   task automatic t_rx;
      int n;
      wb(1'b1, 12'h140, 8'h40);
      wb(1'b1, 12'h140, 8'h77);
      wb(1'b0, 12'h144, 8'h00);
      wb(1'b1, 12'h140, 8'hb7);
      go <= 1'b1;
      n = 0;
      do begin
         wb(1'b0, 12'h160, 8'h00);
         n++;
      end while (q[0] !== 1'b1 && n < 100);
      wb(1'b1, 12'h140, 8'h37);
      rdc(12'h144, 32'ha5, "rx byte");
      go <= 1'b0;
   endtask
   task automatic t_twi;
      int n;
      wb(1'b1, 12'h140, 8'h77);
      wb(1'b1, 12'h140, 8'h41);
      wb(1'b1, 12'h14c, 8'h08);
      wb(1'b1, 12'h14c, 8'hf8);
      repeat (40) @(posedge clk);
      wb(1'b0, 12'h14c, 8'h00);
      chk("start status", 32'hee, {q[31:1], 1'b0});
      chk("lines driven", 32'h0, {30'h0, sdaOeN, sclOeN});
      holdScl <= 1'b1;
      wb(1'b1, 12'h14c, 8'h18);
      chk("lines freed", 32'h3, {30'h0, sdaOeN, sclOeN});
      rdc(12'h14c, 32'h1e, "clock held");
      holdScl <= 1'b0;
      n = 0;
      do begin
         wb(1'b0, 12'h14c, 8'h00);
         n++;
      end while (q[0] !== 1'b1 && n < 10);
      chk("bus free", 32'h1f, q);
      repeat (235) @(posedge clk);
      wb(1'b1, 12'h140, 8'h51);
      wb(1'b1, 12'h144, 8'ha1);
      wb(1'b1, 12'h14c, 8'hf8);
      repeat (40) @(posedge clk);
      chk("restart driven", 32'h0, {30'h0, sdaOeN, sclOeN});
      wb(1'b1, 12'h14c, 8'h00);
      rdc(12'h14c, 32'hf3, "port mode");
   endtask
   initial begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end
   initial begin
      repeat (20000) @(posedge clk);
      miscompares++;
      give_verdict();
   end
   initial begin
      srst = 1'b1;
      {wbCyc, wbStb, wbWe, go, holdScl} = 5'h0;
      wbAdr = 12'h0;
      wbSel = 4'h0;
      wbDatW = 32'h0;
      repeat (20) @(posedge clk);
      srst <= 1'b0;
      @(posedge clk);
      t_regs();
      t_tx();
      t_rx();
      t_twi();
      give_verdict();
   end
endmodule
`default_nettype wire
